// [logic/spp_port.sv]
`timescale 1ns/1ps
`default_nettype none
module spp_port
   import spp_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic irq_ack_i,
   output logic irq_o,
   output logic [1:0] irq_level_o,
   input wire logic ss_as_input_i,
   input wire logic ss_n_i,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_o,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_o
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic out_bit(input logic [7:0] d, input logic lsb);
      out_bit = lsb ? d[0] : d[7];
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b,
                                           input logic lsb);
      shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
   endfunction

   function automatic logic [6:0] half_of(input logic dbl, input logic [1:0] p);
      logic [6:0] h;
      h = HALF_DIV4;
      case ({dbl, p})
         3'h0: h = HALF_DIV4;
         3'h1: h = HALF_DIV16;
         3'h2: h = HALF_DIV64;
         3'h3: h = HALF_DIV128;
         3'h4: h = HALF_DIV2;
         3'h5: h = HALF_DIV8;
         3'h6: h = HALF_DIV32;
         3'h7: h = HALF_DIV64;
         default: h = HALF_DIV4;
      endcase
      half_of = h;
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   spp_state_t s_q;
   spp_state_t s_d;
   logic req;
   logic acc;
   logic aligned;
   logic [1:0] idx;
   logic data_wr;
   logic data_acc;
   logic status_rd;
   logic en;
   logic is_master;
   logic cpol;
   logic cpha;
   logic lsb;
   logic busy;
   logic tick;
   logic set_if;
   logic set_wc;
   logic mode_fault;
   logic [6:0] half;
   logic [7:0] nsh;
   logic rise;
   logic fall;
   logic s_sample;
   logic s_setup;

   always_comb begin
      s_d = s_q;
      nsh = s_q.sh;
      set_if = 1'b0;
      set_wc = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      s_sample = 1'b0;
      s_setup = 1'b0;
      req = avs_read_i | avs_write_i;
      // one wait cycle: readdata is registered in it
      acc = req & s_q.ack;
      s_d.ack = req & ~s_q.ack;
      aligned = (avs_address_i[1:0] == 2'h0);
      idx = avs_address_i[3:2];
      data_acc = acc & aligned & (idx == IDX_SHIFT_DATA);
      data_wr = data_acc & avs_write_i & avs_byteenable_i[0];
      status_rd = acc & aligned & avs_read_i & (idx == IDX_FLAG_STATUS);
      en = s_q.cfg[POS_ENABLE];
      is_master = s_q.cfg[POS_MASTER];
      cpol = s_q.cfg[POS_MODE_POL];
      cpha = s_q.cfg[POS_MODE_PHA];
      lsb = s_q.cfg[POS_BIT_ORDER];
      busy = (s_q.mst == SPP_RUN) | (~is_master & (s_q.scnt != 4'h0));
      half = half_of(s_q.cfg[POS_CLOCK_DOUBLE], s_q.cfg[POS_PRESC_HI:POS_PRESC_LO]);
      tick = (s_q.mst == SPP_RUN) & (s_q.div == (half - 7'h01));
      mode_fault = en & is_master & ss_as_input_i & ~ss_n_i;

      // ------------------------------------------------------------
      // bus read capture, taken in the wait cycle
      // ------------------------------------------------------------
      if (avs_read_i & ~s_q.ack) begin
         s_d.rdata = 8'h00;
         if (aligned) begin
            case (idx)
               IDX_SPI_CONFIG: s_d.rdata = s_q.cfg;
               IDX_IRQ_CONFIG: s_d.rdata = {6'h00, s_q.lvl};
               IDX_FLAG_STATUS: s_d.rdata = {s_q.if_f, s_q.wc_f, 6'h00};
               IDX_SHIFT_DATA: s_d.rdata = s_q.rx;
               default: s_d.rdata = 8'h00;
            endcase
         end
      end

      // ------------------------------------------------------------
      // register writes
      // ------------------------------------------------------------
      if (acc & avs_write_i & avs_byteenable_i[0] & aligned) begin
         if (idx == IDX_SPI_CONFIG) begin
            s_d.cfg = avs_writedata_i[7:0];
         end
         if (idx == IDX_IRQ_CONFIG) begin
            s_d.lvl = avs_writedata_i[1:0];
         end
      end

      // ------------------------------------------------------------
      // master engine
      // ------------------------------------------------------------
      if (s_q.mst == SPP_RUN) begin
         if (tick) begin
            s_d.div = 7'h00;
            s_d.sck = ~s_q.sck;
            s_d.edges = s_q.edges + 5'h01;
            if (s_q.edges[0] == cpha) begin
               nsh = shift_in(s_q.sh, miso_i, lsb);
               s_d.sh = nsh;
            end else begin
               s_d.out_b = out_bit(s_q.sh, lsb);
            end
            if (s_q.edges == LAST_EDGE) begin
               s_d.mst = SPP_IDLE;
               s_d.rx = nsh;
               set_if = 1'b1;
            end
         end else begin
            s_d.div = s_q.div + 7'h01;
         end
      end else begin
         s_d.sck = cpol;
         s_d.div = 7'h00;
         s_d.edges = 5'h00;
      end

      // ------------------------------------------------------------
      // slave engine, clocked by sampled edges of the serial clock
      // ------------------------------------------------------------
      s_d.sck_prev = sck_i;
      if (~is_master) begin
         // divider is never consulted here
         s_d.mst = SPP_IDLE;
         if (ss_n_i | ~en) begin
            s_d.scnt = 4'h0;
         end else begin
            rise = sck_i & ~s_q.sck_prev;
            fall = ~sck_i & s_q.sck_prev;
            s_sample = cpha ? (cpol ? rise : fall) : (cpol ? fall : rise);
            s_setup = cpha ? (cpol ? fall : rise) : (cpol ? rise : fall);
            if (s_sample) begin
               nsh = shift_in(s_q.sh, mosi_i, lsb);
               s_d.sh = nsh;
               s_d.scnt = s_q.scnt + 4'h1;
               if (s_q.scnt == LAST_BIT) begin
                  s_d.scnt = 4'h0;
                  s_d.rx = nsh;
                  set_if = 1'b1;
               end
            end else if (s_setup | (~cpha & (s_q.scnt == 4'h0))) begin
               s_d.out_b = out_bit(s_q.sh, lsb);
            end
         end
      end

      if (~en) begin
         s_d.mst = SPP_IDLE;
      end

      // ------------------------------------------------------------
      // data write: start or collide
      // ------------------------------------------------------------
      if (data_wr) begin
         if (busy) begin
            set_wc = 1'b1;
         end else begin
            s_d.sh = avs_writedata_i[7:0];
            if (~cpha) begin
               s_d.out_b = out_bit(avs_writedata_i[7:0], lsb);
            end
            if (en & is_master) begin
               s_d.mst = SPP_RUN;
               s_d.div = 7'h00;
               s_d.edges = 5'h00;
            end
         end
      end

      // ------------------------------------------------------------
      // another master pulls select low
      // ------------------------------------------------------------
      if (mode_fault) begin
         s_d.cfg[POS_MASTER] = 1'b0;
         s_d.mst = SPP_IDLE;
         set_if = 1'b1;
      end

      // ------------------------------------------------------------
      // flags: clears first so a same-cycle set wins
      // ------------------------------------------------------------
      if (data_acc) begin
         if (s_q.if_arm) begin
            s_d.if_f = 1'b0;
         end
         if (s_q.wc_arm) begin
            s_d.wc_f = 1'b0;
         end
         s_d.if_arm = 1'b0;
         s_d.wc_arm = 1'b0;
      end
      if (status_rd) begin
         s_d.if_arm = s_q.if_f;
         s_d.wc_arm = s_q.wc_f;
      end
      if (irq_ack_i) begin
         s_d.if_f = 1'b0;
      end
      if (set_if) begin
         s_d.if_f = 1'b1;
      end
      if (set_wc) begin
         s_d.wc_f = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.cfg <= RST_SPI_CONFIG;
         s_q.lvl <= RST_IRQ_LEVEL;
         s_q.rx <= RST_DATA;
         s_q.sh <= RST_DATA;
         s_q.mst <= SPP_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign avs_waitrequest_o = req & ~s_q.ack;
   assign avs_readdata_o = {24'h000000, s_q.rdata};
   assign irq_o = (s_q.lvl != 2'h0) & s_q.if_f;
   assign irq_level_o = s_q.lvl;
   assign sck_o = s_q.sck;
   assign sck_oe_o = en & is_master;
   assign mosi_o = s_q.out_b;
   assign mosi_oe_o = en & is_master;
   assign miso_o = s_q.out_b;
   // select high keeps the slave output released
   assign miso_oe_o = en & ~is_master & ~ss_n_i;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   sequence s_last_edge;
      (s_q.mst == SPP_RUN) && tick && (s_q.edges == LAST_EDGE);
   endsequence

   sequence s_stopped;
      (s_q.mst == SPP_IDLE) && s_q.if_f;
   endsequence

   a_disabled_no_run: assert property (!en |=> s_q.mst == SPP_IDLE)
      else $error("master engine runs while disabled");
   a_sck_idle_level: assert property ((s_q.mst == SPP_IDLE) && en && is_master
      |=> sck_o == $past(cpol))
      else $error("serial clock not at idle level");
   a_master_stops: assert property (s_last_edge |=> s_stopped)
      else $error("master did not stop after eight bits");
   a_mode_fault_slave: assert property (mode_fault |=> !is_master && s_q.if_f)
      else $error("select fault did not drop master mode");
   a_wcol_sets: assert property (data_wr && busy |=> s_q.wc_f)
      else $error("collision flag not set");
   a_shift_kept: assert property (data_wr && busy && !tick && !s_sample
      |=> $stable(s_q.sh))
      else $error("colliding write disturbed the shift register");
   a_slave_released: assert property (!is_master && ss_n_i |-> !miso_oe_o)
      else $error("slave output driven while deselected");
   a_slave_drop: assert property (!is_master && $rose(ss_n_i)
      |=> s_q.scnt == 4'h0)
      else $error("partial byte kept after deselect");
   a_rate_div4: assert property ((s_q.mst == SPP_RUN) && tick && !s_q.cfg[7]
      && (s_q.cfg[1:0] == 2'h0) && (s_q.edges != LAST_EDGE) && $stable(s_q.cfg)
      |=> !tick ##1 tick)
      else $error("divide by four rate wrong");
   a_rate_div2: assert property ((s_q.mst == SPP_RUN) && tick && s_q.cfg[7]
      && (s_q.cfg[1:0] == 2'h0) && (s_q.edges != LAST_EDGE) && $stable(s_q.cfg)
      |=> tick)
      else $error("double speed rate wrong");
   a_irq_request: assert property (s_q.if_f && (s_q.lvl != 2'h0) |-> irq_o)
      else $error("interrupt not requested");
   a_vector_clear: assert property (irq_ack_i && !set_if |=> !s_q.if_f)
      else $error("vector did not clear completion flag");
   a_if_two_step: assert property (data_acc && s_q.if_arm && !set_if
      |=> !s_q.if_f)
      else $error("completion flag not cleared by status then data");
   a_wc_two_step: assert property (data_acc && s_q.wc_arm && !set_wc
      |=> !s_q.wc_f)
      else $error("collision flag not cleared by status then data");
   a_write_starts: assert property (data_wr && !busy && en && is_master && !mode_fault
      |=> s_q.mst == SPP_RUN)
      else $error("data write did not start transfer");

   // ---------------------------------------------------------------
   // shift path and register checks
   // ---------------------------------------------------------------
   a_rx_readback: assert property (avs_read_i && !s_q.ack && aligned
      && (idx == IDX_SHIFT_DATA) |=> s_q.rdata == $past(s_q.rx))
      else $error("data read did not return the receive buffer");
   a_cfg_write: assert property (acc && avs_write_i && avs_byteenable_i[0] && aligned
      && (idx == IDX_SPI_CONFIG) && !mode_fault |=> s_q.cfg == $past(avs_writedata_i[7:0]))
      else $error("config write did not land");
   a_first_bit: assert property (data_wr && !busy && !cpha
      |=> mosi_o == $past(lsb ? avs_writedata_i[0] : avs_writedata_i[7]))
      else $error("first bit not presented after data write");
   a_master_miso: assert property ((s_q.mst == SPP_RUN) && tick
      && (s_q.edges[0] == cpha) |=> ($past(lsb) ? s_q.sh[7] : s_q.sh[0]) == $past(miso_i))
      else $error("master sampled the wrong input bit");
   a_master_setup: assert property ((s_q.mst == SPP_RUN) && tick
      && (s_q.edges[0] != cpha) |=> mosi_o == $past(lsb ? s_q.sh[0] : s_q.sh[7]))
      else $error("master set up the wrong output bit");
   a_slave_sample: assert property (s_sample && !data_wr
      |=> ($past(lsb) ? s_q.sh[7] : s_q.sh[0]) == $past(mosi_i))
      else $error("slave sampled the wrong input bit");
   a_slave_last: assert property (s_sample && (s_q.scnt == LAST_BIT)
      |=> s_q.if_f && (s_q.scnt == 4'h0))
      else $error("slave byte end not flagged");
   a_slave_count: assert property (!is_master && !ss_n_i && en && !s_sample
      |=> $stable(s_q.scnt))
      else $error("slave bit count moved without a sample edge");
   a_slave_idle: assert property (!is_master && ss_n_i && !data_wr
      && (s_q.mst == SPP_IDLE) |=> $stable(s_q.sh))
      else $error("deselected slave shifted data");
   a_disabled_slave: assert property (!en && !is_master |=> s_q.scnt == 4'h0)
      else $error("disabled slave kept a bit count");
endmodule
`default_nettype wire

// [logic/spp_pkg.sv]
// Operation
// - clock double in master mode doubles the serial clock rate.
// - no serial transfer happens unless the enable bit is one.
// - bit order one shifts lsb first, zero shifts msb first.
// - role bit one selects master, zero selects slave.
// - select input low while master clears role bit, falls back to slave.
// - mode field picks leading edge polarity and sample or setup phase.
// - serial clock idles low for rising leading edge, high for falling.
// - without clock double, divide by 4, 16, 64 or 128.
// - with clock double, divide by 2, 8, 32 or 64.
// - divider selection has no effect in slave mode.
// - nonzero interrupt level requests interrupt while completion flag is set.
// - completion flag sets once a full byte is shifted.
// - select input low while master also sets completion flag.
// - completion flag clears when the interrupt vector executes.
// - status read with flag set, then data access, clears completion flag.
// - data write during a transfer sets the collision flag.
// - status read with collision set, then data access, clears it.
// - data write starts a transmission of the written byte.
// - data read returns the last completely received byte.
// - slave with select high keeps its output off and ignores clocks.
// - select rising in slave resets shift logic, drops partial byte.
// - master stops clock after eight bits and sets completion flag.
package spp_pkg;
   // ---------------------------------------------------------------
   // register map: index, byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [1:0] IDX_SPI_CONFIG = 2'h0;
   localparam logic [1:0] IDX_IRQ_CONFIG = 2'h1;
   localparam logic [1:0] IDX_FLAG_STATUS = 2'h2;
   localparam logic [1:0] IDX_SHIFT_DATA = 2'h3;
   localparam logic [7:0] RST_SPI_CONFIG = 8'h00;
   localparam logic [1:0] RST_IRQ_LEVEL = 2'h0;
   localparam logic [7:0] RST_DATA = 8'h00;
   // ---------------------------------------------------------------
   // spi_config and flag_status field positions
   // ---------------------------------------------------------------
   localparam int POS_CLOCK_DOUBLE = 7;
   localparam int POS_ENABLE = 6;
   localparam int POS_BIT_ORDER = 5;
   localparam int POS_MASTER = 4;
   localparam int POS_MODE_POL = 3;
   localparam int POS_MODE_PHA = 2;
   localparam int POS_PRESC_HI = 1;
   localparam int POS_PRESC_LO = 0;
   localparam int POS_IF = 7;
   localparam int POS_WCOL = 6;
   // ---------------------------------------------------------------
   // half periods of the serial clock in peripheral clock cycles
   // ---------------------------------------------------------------
   localparam logic [6:0] HALF_DIV2 = 7'h01;
   localparam logic [6:0] HALF_DIV4 = 7'h02;
   localparam logic [6:0] HALF_DIV8 = 7'h04;
   localparam logic [6:0] HALF_DIV16 = 7'h08;
   localparam logic [6:0] HALF_DIV32 = 7'h10;
   localparam logic [6:0] HALF_DIV64 = 7'h20;
   localparam logic [6:0] HALF_DIV128 = 7'h40;
   localparam logic [4:0] LAST_EDGE = 5'h0F;
   localparam logic [3:0] LAST_BIT = 4'h7;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SPP_IDLE = 2'b01,
      SPP_RUN = 2'b10
   } spp_mst_t;
   typedef struct packed {
      logic [7:0] cfg;
      logic [1:0] lvl;
      logic if_f;
      logic wc_f;
      logic if_arm;
      logic wc_arm;
      logic [7:0] rx;
      logic [7:0] sh;
      logic out_b;
      logic sck;
      logic [4:0] edges;
      logic [6:0] div;
      spp_mst_t mst;
      logic sck_prev;
      logic [3:0] scnt;
      logic ack;
      logic [7:0] rdata;
   } spp_state_t;
endpackage

// [dv/spp_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// far-side serial device, behavioural
// ---------------------------------------------------------------
module spp_partner (
   input wire logic sck_i,
   input wire logic ss_n_i,
   input wire logic mosi_i,
   input wire logic [1:0] mode_i,
   input wire logic lsb_i,
   input wire logic [7:0] tx_i,
   output logic miso_o,
   output logic [7:0] rx_o
);
   logic [7:0] sh;
   int n;
   logic lead;
   initial miso_o = 1'b0;
   always @(negedge ss_n_i) begin
      sh = tx_i;
      n = 0;
      miso_o = lsb_i ? tx_i[0] : tx_i[7];
   end
   // released line shows the inverse, never a stale level
   always @(posedge ss_n_i) miso_o = ~miso_o;
   always @(sck_i) begin
      if (!ss_n_i) begin
         lead = (sck_i != mode_i[1]);
         if (lead == !mode_i[0]) begin
            sh = lsb_i ? {mosi_i, sh[7:1]} : {sh[6:0], mosi_i};
            n++;
            if (n == 8) rx_o = sh;
         end else begin
            miso_o = lsb_i ? sh[0] : sh[7];
         end
      end
   end
endmodule
`default_nettype wire

// [dv/spp_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module spp_port_tb;
   import spp_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam logic [3:0] A_CFG = {IDX_SPI_CONFIG, 2'h0};
   localparam logic [3:0] A_IRQ = {IDX_IRQ_CONFIG, 2'h0};
   localparam logic [3:0] A_ST = {IDX_FLAG_STATUS, 2'h0};
   localparam logic [3:0] A_DAT = {IDX_SHIFT_DATA, 2'h0};
   logic clock_i, rst_i, avs_read_i, avs_write_i, irq_ack_i, ss_as_input_i, ss_n_i;
   logic sck_i, mosi_i, avs_waitrequest_o, irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o;
   logic miso_o, miso_oe_o, miso_i, p_ss_n, p_lsb, sck_last;
   logic [3:0] avs_address_i, avs_byteenable_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic [1:0] irq_level_o, p_mode;
   logic [7:0] p_tx, p_rx, got;
   int failures = 0, cmp_count = 0, cyc = 0, tog = 0, run = 0, half = 0, t0;
   int hd[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
   spp_port dut (.clock_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .irq_ack_i, .irq_o, .irq_level_o, .ss_as_input_i, .ss_n_i, .sck_i, .sck_o,
      .sck_oe_o, .mosi_i, .mosi_o, .mosi_oe_o, .miso_i, .miso_o, .miso_oe_o);
   spp_partner partner (.sck_i(sck_o), .ss_n_i(p_ss_n), .mosi_i(mosi_o), .mode_i(p_mode),
      .lsb_i(p_lsb), .tx_i(p_tx), .miso_o(miso_i), .rx_o(p_rx));
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   // ---------------------------------------------------------------
   // monitors: serial clock toggles and half period, hang limit
   // ---------------------------------------------------------------
   always @(posedge clock_i) begin
      cyc++;
      if (sck_o !== sck_last) begin
         tog++;
         half = run;
         run = 1;
      end else begin
         run++;
      end
      sck_last = sck_o;
      if (cyc > 20000) begin
         failures++;
         end_of_test();
      end
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
      end
   endtask
   // one bus cycle; waits on waitrequest, takes data at that edge
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= {24'h0, d};
      avs_write_i <= w;
      avs_read_i <= !w;
      do begin
         @(posedge clock_i);
      end while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   task automatic poll();
      int k;
      k = 0;
      rd = 32'h0;
      while (rd[7] !== 1'b1 && k < 800) begin
         acc(0, A_ST, 8'h00);
         k++;
      end
   endtask
   // master byte against the partner; col adds a write while busy
   task automatic mxfer(input logic [7:0] cfg, input logic [7:0] d, input logic [7:0] t,
                        input logic col);
      acc(1, A_CFG, cfg);
      p_mode <= cfg[3:2];
      p_lsb <= cfg[5];
      p_tx <= t;
      repeat (4) @(posedge clock_i);
      p_ss_n <= 1'b0;
      t0 = tog;
      acc(1, A_DAT, d);
      if (col) acc(1, A_DAT, ~d);
      poll();
      p_ss_n <= 1'b1;
   endtask
   // bench as far master, mode 0 msb first, four cycles per level
   task automatic slv(input logic [7:0] d, input int nb);
      ss_n_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      chk("slave oe", {sck_oe_o, mosi_oe_o, miso_oe_o}, 32'h1);
      for (int k = 7; k > 7 - nb; k--) begin
         mosi_i <= d[k];
         repeat (4) @(posedge clock_i);
         sck_i <= 1'b1;
         got[k] = miso_o;
         repeat (4) @(posedge clock_i);
         sck_i <= 1'b0;
      end
      repeat (4) @(posedge clock_i);
      ss_n_i <= 1'b1;
      mosi_i <= ~mosi_i;
      repeat (4) @(posedge clock_i);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst_i, avs_read_i, avs_write_i, irq_ack_i, ss_as_input_i} = 5'h10;
      {ss_n_i, sck_i, mosi_i, p_ss_n, p_lsb} = 5'h12;
      avs_address_i = 4'h0;
      avs_byteenable_i = 4'hF;
      avs_writedata_i = 32'h0;
      p_mode = 2'h0;
      p_tx = 8'h00;
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         acc(0, 4'(i * 4), 8'h00);
         chk("reset value", rd, 32'h0);
      end
      acc(1, A_IRQ, 8'hFF);
      acc(0, A_IRQ, 8'h00);
      chk("irq_config", rd, 32'h3);
      chk("irq_level_o", irq_level_o, 32'h3);
      acc(1, A_ST, 8'hFF);
      acc(0, A_ST, 8'h00);
      chk("flag_status ro", rd, 32'h0);
      acc(1, 4'h1, 8'hFF);
      acc(0, 4'h1, 8'h00);
      chk("unmapped", rd, 32'h0);
      acc(1, A_CFG, 8'hB5);
      acc(0, A_CFG, 8'h00);
      chk("spi_config", rd, 32'hB5);
      // disabled port must not shift
      t0 = tog;
      acc(1, A_DAT, 8'h3C);
      repeat (40) @(posedge clock_i);
      chk("disabled toggles", tog - t0, 32'h0);
      acc(0, A_ST, 8'h00);
      chk("disabled flag", rd, 32'h0);
      // every divider code, clock double, mode and bit order
      for (int i = 0; i < 8; i++) begin
         mxfer({i[2], 1'b1, i[0], 1'b1, i[1:0], i[1:0]}, 8'h96 ^ 8'(i * 17), 8'h5A + 8'(i), 0);
         chk("toggles", tog - t0, 32'd16);
         chk("half period", half, hd[i]);
         chk("sck idle", sck_o, {31'h0, i[1]});
         chk("done flag", rd, 32'h80);
         chk("irq_o", irq_o, 32'h1);
         chk("pin enables", {sck_oe_o, mosi_oe_o, miso_oe_o}, 32'h6);
         acc(0, A_DAT, 8'h00);
         chk("rx byte", rd, 32'h5A + i);
         chk("tx byte", p_rx, 8'h96 ^ 8'(i * 17));
         acc(0, A_ST, 8'h00);
         chk("flag cleared", rd, 32'h0);
      end
      // collision while shifting
      mxfer(8'h50, 8'h81, 8'hC3, 1);
      chk("collision", rd, 32'hC0);
      chk("byte kept", p_rx, 8'h81);
      irq_ack_i <= 1'b1;
      @(posedge clock_i);
      irq_ack_i <= 1'b0;
      acc(0, A_ST, 8'h00);
      chk("vector clear", rd, 32'h40);
      acc(0, A_DAT, 8'h00);
      acc(0, A_ST, 8'h00);
      chk("collision clear", rd, 32'h0);
      // select input pulled low while master
      acc(1, A_IRQ, 8'h00);
      ss_as_input_i <= 1'b1;
      ss_n_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      chk("irq off", irq_o, 32'h0);
      acc(0, A_CFG, 8'h00);
      chk("fallback", rd, 32'h40);
      acc(0, A_ST, 8'h00);
      chk("fault flag", rd, 32'h80);
      acc(1, A_IRQ, 8'h02);
      @(posedge clock_i);
      chk("irq on", irq_o, 32'h1);
      ss_n_i <= 1'b1;
      ss_as_input_i <= 1'b0;
      acc(0, A_DAT, 8'h00);
      // slave, divider bits set but without effect
      acc(1, A_CFG, 8'h43);
      chk("miso off", miso_oe_o, 32'h0);
      acc(1, A_DAT, 8'hA5);
      slv(8'h3C, 3);
      acc(0, A_ST, 8'h00);
      chk("partial", rd, 32'h0);
      acc(1, A_DAT, 8'hA5);
      slv(8'h69, 8);
      chk("slave out", got, 8'hA5);
      acc(0, A_ST, 8'h00);
      chk("slave flag", rd, 32'h80);
      acc(0, A_DAT, 8'h00);
      chk("slave rx", rd, 32'h69);
      end_of_test();
   end
endmodule
`default_nettype wire
